// >>> rtl/pmbmr_pkg.sv
// constants and types for the margin, scale, frequency and turn-on registers
package pmbmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command codes and storage slots
  localparam int         NUM_REGS  = 5;
  localparam logic [7:0] CODE_MH    = 8'h25;
  localparam logic [7:0] CODE_ML    = 8'h26;
  localparam logic [7:0] CODE_SCALE = 8'h29;
  localparam logic [7:0] CODE_FREQ  = 8'h33;
  localparam logic [7:0] CODE_VIN   = 8'h35;
  localparam logic [2:0] IDX_MH     = 3'h0;
  localparam logic [2:0] IDX_ML     = 3'h1;
  localparam logic [2:0] IDX_SCALE  = 3'h2;
  localparam logic [2:0] IDX_FREQ   = 3'h3;
  localparam logic [2:0] IDX_VIN    = 3'h4;
  localparam logic [2:0] IDX_LAST   = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // fixed fields and reset values
  localparam logic [15:0] MH_RESET         = 16'h0547;
  localparam logic [15:0] ML_RESET         = 16'h0451;
  localparam logic [4:0]  SCALE_EXP        = 5'h17;
  localparam logic [10:0] SCALE_MANT_RESET = 11'h100;
  localparam logic [10:0] SCALE_MANT_MAX   = 11'h200;
  localparam logic [4:0]  FREQ_EXP         = 5'h05;
  localparam logic [5:0]  FREQ_MANT_RESET  = 6'h13;
  localparam logic [4:0]  VIN_EXP          = 5'h1e;
  localparam logic [6:0]  VIN_MANT_RESET   = 7'h0b;
  localparam logic [6:0]  VIN_MANT_MIN     = 7'h0b;
  localparam logic [6:0]  VIN_MANT_MAX     = 7'h48;
  localparam logic [15:0] SCALE_RESET = {SCALE_EXP, SCALE_MANT_RESET};
  localparam logic [15:0] FREQ_RESET  = {FREQ_EXP, 5'h00, FREQ_MANT_RESET};
  localparam logic [15:0] VIN_RESET   = {VIN_EXP, 4'h0, VIN_MANT_RESET};
  localparam logic [79:0] NVM_INIT    = {VIN_RESET, FREQ_RESET, SCALE_RESET,
                                         ML_RESET, MH_RESET};

  ////////////////////////////////////////////////////////////////////////////
  // loop reference in units of 2^-19 volt: nominal, +25 % and -25 %
  localparam logic [19:0] REF_NOM = 20'h4cccd;
  localparam logic [19:0] REF_HI  = 20'h60000;
  localparam logic [19:0] REF_LO  = 20'h3999a;

  // supported switching rates as mantissas of 32 kHz, rounded up
  localparam int         FREQ_STEPS = 14;
  localparam logic [5:0] FREQ_STEP [0:13] = '{
    6'h07, 6'h0a, 6'h0d, 6'h10, 6'h13, 6'h16, 6'h19,
    6'h1d, 6'h20, 6'h26, 6'h2c, 6'h32, 6'h39, 6'h3c};

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_MULT  = 3'b001,
    ST_CHECK = 3'b011,
    ST_STORE = 3'b010,
    ST_RREAD = 3'b110,
    ST_RLOAD = 3'b111
  } pmbmr_state_t;

  typedef enum logic [1:0] {
    MODE_NOM  = 2'b00,
    MODE_LOW  = 2'b01,
    MODE_HIGH = 2'b10
  } pmbmr_mode_t;

  typedef enum logic [1:0] {
    NVM_STORE_ALL   = 2'b00,
    NVM_STORE_ONE   = 2'b01,
    NVM_RESTORE_ALL = 2'b10,
    NVM_RESTORE_ONE = 2'b11
  } pmbmr_nvm_op_t;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } pmbmr_cmd_t;

  typedef struct packed {
    pmbmr_state_t st;
    logic [2:0]   walk;
    logic         walk_all;
    logic [14:0]  mh;
    logic [14:0]  ml;
    logic [10:0]  scale;
    logic [5:0]   freq;
    logic [6:0]   vin;
    pmbmr_mode_t  mode;
    logic [16:0]  sum;
    logic [28:0]  prod;
    logic [19:0]  ref_cmd;
    logic [16:0]  vout_cmd;
    logic         cml;
    logic         ivd;
    logic         alert_n;
    logic         ready;
    logic         rsp_valid;
    logic         rsp_ack;
    logic [15:0]  rsp_data;
  } pmbmr_regs_t;

endpackage

// >>> rtl/pmbmr_nvm.sv
// small default store for the five registers, registered read data
module pmbmr_nvm
  import pmbmr_pkg::*;
#(
  parameter int                      WIDTH = 16,
  parameter int                      DEPTH = NUM_REGS,
  parameter logic [WIDTH*DEPTH-1:0]  INIT  = NVM_INIT
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // write port
  input  wire logic              wr_en,
  input  wire logic [2:0]        wr_addr,
  input  wire logic [WIDTH-1:0]  wr_data,
  // read port
  input  wire logic              rd_en,
  input  wire logic [2:0]        rd_addr,
  output logic      [WIDTH-1:0]  rd_data
);

  // the address ports are three bits wide, so eight slots at most
  if (DEPTH < 1 || DEPTH > 8 || WIDTH < 1) begin : g_bad_size
    $error("pmbmr_nvm: depth must be 1 to 8 and width at least 1");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rd_data;
  } pmbmr_nvm_regs_t;

  pmbmr_nvm_regs_t r;
  pmbmr_nvm_regs_t next_r;

  ////////////////////////////////////////////////////////////////////////////
  // out-of-range addresses are dropped on write and read as zero
  always_comb begin
    next_r = r;
    if (wr_en && int'(wr_addr) < DEPTH) begin
      next_r.mem[wr_addr] = wr_data;
    end
    if (rd_en) begin
      next_r.rd_data = (int'(rd_addr) < DEPTH) ? r.mem[rd_addr] : '0;
    end
  end

  // reset stands in for power-up: the slots come up holding the defaults
  always_ff @(posedge mclk) begin
    if (reset) begin
      r <= {INIT, {WIDTH{1'b0}}};
    end else begin
      r <= next_r;
    end
  end

  assign rd_data = r.rd_data;

endmodule

// >>> rtl/pmbmr_regs.sv
// margin, loop scale, switching rate and turn-on threshold command registers
//
// Notes on behaviour
// - margin-high output is (margin-high + trim) times 2^-10.
// - margin writes are stored unchecked; checking waits for a margin request.
// - margin target beyond +/-25 % of nominal sets cml and invalid-data.
// - out-of-range margin target clamps ref_cmd to the limit on its side; vout_cmd keeps the unclamped target.
// - margin-high resets to 0x547; sign bit reads as fixed.
// - margin-low resets to 0x451; target is (margin-low + trim) times 2^-10.
// - loop scale exponent is fixed at -9; only the mantissa is writable.
// - loop scale mantissa defaults to 256 and never exceeds 512.
// - margin output-voltage computations use the current loop scale; nominal loads REF_NOM.
// - in-range rate writes round up to the next supported step.
// - fourteen rates from 200 kHz to 1.9 MHz, 600 kHz default.
// - rate exponent fixed at 5, upper mantissa zero, low six bits default 19.
// - turn-on writes map to nearest of 2.75 V, 3.00 to 18.00 V.
// - out-of-range turn-on write keeps old value, sets cml and invalid-data.
// - turn-on must exceed turn-off; violating writes rejected with alert.
// - turn-on exponent fixed at -2, upper four mantissa zero, default 11.
// - all five registers can be stored to the default store.
module pmbmr_regs
  import pmbmr_pkg::*;
(
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          reset,
  // command access: one request per cycle while ready
  input  wire logic          cmd_valid,
  input  wire pmbmr_cmd_t    cmd,
  output logic               cmd_ready,
  output logic               rsp_valid,
  output logic               rsp_ack,
  output logic [15:0]        rsp_data,
  // operation state request and loop inputs
  input  wire logic          op_valid,
  input  wire pmbmr_mode_t   op_mode,
  input  wire logic [15:0]   trim,
  input  wire logic [6:0]    vin_off,
  // default store requests
  input  wire logic          nvm_valid,
  input  wire pmbmr_nvm_op_t nvm_op,
  input  wire logic [7:0]    nvm_code,
  // status handling
  input  wire logic          clear_faults,
  output logic               cml,
  output logic               ivd,
  output logic               smbalert_n,
  // settings seen by the power stage
  output logic [19:0]        ref_cmd,
  output logic [16:0]        vout_cmd,
  output logic [10:0]        scale_mant,
  output logic [5:0]         freq_mant,
  output logic [6:0]         input_start_threshold_mant
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // command code to storage slot, top bit flags a supported code
  function automatic logic [3:0] code_slot(input logic [7:0] code);
    case (code)
      CODE_MH:    code_slot = {1'b1, IDX_MH};
      CODE_ML:    code_slot = {1'b1, IDX_ML};
      CODE_SCALE: code_slot = {1'b1, IDX_SCALE};
      CODE_FREQ:  code_slot = {1'b1, IDX_FREQ};
      CODE_VIN:   code_slot = {1'b1, IDX_VIN};
      default:    code_slot = 4'h0;
    endcase
  endfunction

  // read view: fixed exponents and zero fields come from constants
  function automatic logic [15:0] read_view(input pmbmr_regs_t s,
                                            input logic [2:0]  idx);
    case (idx)
      IDX_MH:    read_view = {1'b0, s.mh};
      IDX_ML:    read_view = {1'b0, s.ml};
      IDX_SCALE: read_view = {SCALE_EXP, s.scale};
      IDX_FREQ:  read_view = {FREQ_EXP, 5'h00, s.freq};
      IDX_VIN:   read_view = {VIN_EXP, 4'h0, s.vin};
      default:   read_view = 16'h0000;
    endcase
  endfunction

  // smallest supported rate at or above the request, top step beyond
  function automatic logic [5:0] freq_round(input logic [5:0] m);
    freq_round = FREQ_STEP[FREQ_STEPS-1];
    for (int i = FREQ_STEPS - 1; i >= 0; i--) begin
      if (m <= FREQ_STEP[i]) begin
        freq_round = FREQ_STEP[i];
      end
    end
  endfunction

  // quarter-volt code to 2.75 V or a half-volt step; ties round up
  function automatic logic [6:0] vin_map(input logic [6:0] m);
    if (!m[0] || m == VIN_MANT_MIN) begin
      vin_map = m;
    end else begin
      vin_map = m + 7'h01;
    end
  endfunction

  function automatic logic in_scale_range(input logic [10:0] m);
    in_scale_range = (m != 11'h000) && (m <= SCALE_MANT_MAX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state and default store

  localparam pmbmr_regs_t REGS_RESET = '{
    st: ST_IDLE, walk: 3'h0, walk_all: 1'b0,
    mh: MH_RESET[14:0], ml: ML_RESET[14:0],
    scale: SCALE_MANT_RESET, freq: FREQ_MANT_RESET, vin: VIN_MANT_RESET,
    mode: MODE_NOM, sum: 17'h00000, prod: 29'h00000000,
    ref_cmd: REF_NOM, vout_cmd: 17'h00000,
    cml: 1'b0, ivd: 1'b0, alert_n: 1'b1, ready: 1'b1,
    rsp_valid: 1'b0, rsp_ack: 1'b0, rsp_data: 16'h0000};

  pmbmr_regs_t r;
  pmbmr_regs_t next_r;
  logic        mem_we;
  logic [2:0]  mem_wa;
  logic [15:0] mem_wd;
  logic        mem_re;
  logic [2:0]  mem_ra;
  logic [15:0] mem_rd;

  pmbmr_nvm #(
    .WIDTH (16),
    .DEPTH (NUM_REGS),
    .INIT  (NVM_INIT)
  ) u_nvm (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (mem_wd),
    .rd_en   (mem_re),
    .rd_addr (mem_ra),
    .rd_data (mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state: at most one request is taken per idle cycle,
  // command first, then operation, then default store
  always_comb begin
    logic [3:0]  slot;
    logic [3:0]  nslot;
    logic [6:0]  vmap;
    logic [14:0] sel;
    logic        err;
    slot   = code_slot(cmd.code);
    nslot  = code_slot(nvm_code);
    vmap   = vin_map(cmd.wdata[6:0]);
    sel    = (op_mode == MODE_HIGH) ? r.mh : r.ml;
    err    = 1'b0;
    next_r = r;
    next_r.rsp_valid = 1'b0;
    next_r.rsp_ack   = 1'b0;
    mem_we = 1'b0;
    mem_wa = r.walk;
    mem_wd = read_view(r, r.walk);
    mem_re = 1'b0;
    mem_ra = r.walk;
    case (r.st)
      ST_IDLE: begin
        if (cmd_valid) begin
          next_r.rsp_valid = 1'b1;
          next_r.rsp_ack   = slot[3];
          next_r.rsp_data  = (slot[3] && !cmd.write) ?
                             read_view(r, slot[2:0]) : 16'h0000;
          if (cmd.write && slot[3]) begin
            case (slot[2:0])
              IDX_MH: next_r.mh = cmd.wdata[14:0];
              IDX_ML: next_r.ml = cmd.wdata[14:0];
              IDX_SCALE: begin
                if (in_scale_range(cmd.wdata[10:0])) begin
                  next_r.scale = cmd.wdata[10:0];
                end else begin
                  err = 1'b1;
                end
              end
              IDX_FREQ: next_r.freq = freq_round(cmd.wdata[5:0]);
              IDX_VIN: begin
                if (cmd.wdata[10:7] != 4'h0 ||
                    cmd.wdata[6:0] < VIN_MANT_MIN ||
                    cmd.wdata[6:0] > VIN_MANT_MAX) begin
                  err = 1'b1;
                end else if (vmap <= vin_off) begin
                  err = 1'b1;
                end else begin
                  next_r.vin = vmap;
                end
              end
              default: ;
            endcase
          end
        end else if (op_valid) begin
          next_r.mode = op_mode;
          if (op_mode == MODE_HIGH || op_mode == MODE_LOW) begin
            // target code = stored margin + sign-extended trim
            next_r.sum = {2'b00, sel} + {trim[15], trim};
            next_r.st  = ST_MULT;
          end else begin
            next_r.ref_cmd  = REF_NOM;
            next_r.vout_cmd = 17'h00000;
          end
        end else if (nvm_valid) begin
          next_r.walk_all = (nvm_op == NVM_STORE_ALL) ||
                            (nvm_op == NVM_RESTORE_ALL);
          next_r.walk     = next_r.walk_all ? 3'h0 : nslot[2:0];
          // single-code requests to unknown codes are dropped
          if (next_r.walk_all || nslot[3]) begin
            next_r.st = (nvm_op == NVM_STORE_ALL ||
                         nvm_op == NVM_STORE_ONE) ? ST_STORE : ST_RREAD;
          end
        end
      end
      ST_MULT: begin
        // feedback-side voltage: scale the target by the loop scale instead of dividing the limits
        next_r.prod = 29'($signed(r.sum) * $signed({1'b0, r.scale}));
        next_r.st   = ST_CHECK;
      end
      ST_CHECK: begin
        next_r.vout_cmd = r.sum;
        if ($signed(r.prod) > $signed({9'h000, REF_HI})) begin
          next_r.ref_cmd = REF_HI;
          err = 1'b1;
        end else if ($signed(r.prod) < $signed({9'h000, REF_LO})) begin
          next_r.ref_cmd = REF_LO;
          err = 1'b1;
        end else begin
          next_r.ref_cmd = r.prod[19:0];
        end
        next_r.st = ST_IDLE;
      end
      ST_STORE: begin
        mem_we = 1'b1;
        if (r.walk_all && r.walk != IDX_LAST) begin
          next_r.walk = r.walk + 3'h1;
        end else begin
          next_r.st = ST_IDLE;
        end
      end
      ST_RREAD: begin
        mem_re    = 1'b1;
        next_r.st = ST_RLOAD;
      end
      ST_RLOAD: begin
        // stored words went through the write checks once already
        case (r.walk)
          IDX_MH:    next_r.mh    = mem_rd[14:0];
          IDX_ML:    next_r.ml    = mem_rd[14:0];
          IDX_SCALE: next_r.scale = mem_rd[10:0];
          IDX_FREQ:  next_r.freq  = mem_rd[5:0];
          IDX_VIN:   next_r.vin   = mem_rd[6:0];
          default: ;
        endcase
        if (r.walk_all && r.walk != IDX_LAST) begin
          next_r.walk = r.walk + 3'h1;
          next_r.st   = ST_RREAD;
        end else begin
          next_r.st = ST_IDLE;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
    // a new error in the clearing cycle wins over the clear
    next_r.cml   = (r.cml && !clear_faults) || err;
    next_r.ivd   = (r.ivd && !clear_faults) || err;
    next_r.alert_n = !((!r.alert_n && !clear_faults) || err);
    next_r.ready = (next_r.st == ST_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      r <= REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign cmd_ready   = r.ready;
  assign rsp_valid   = r.rsp_valid;
  assign rsp_ack     = r.rsp_ack;
  assign rsp_data    = r.rsp_data;
  assign cml         = r.cml;
  assign ivd         = r.ivd;
  assign smbalert_n  = r.alert_n;
  assign ref_cmd     = r.ref_cmd;
  assign vout_cmd    = r.vout_cmd;
  assign scale_mant  = r.scale;
  assign freq_mant   = r.freq;
  assign input_start_threshold_mant = r.vin;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic        cmd_take;
  logic        op_take;
  logic [16:0] hi_sum;
  logic [28:0] prod_now;
  logic        vin_bad;
  assign cmd_take = cmd_valid && r.ready;
  assign op_take  = op_valid && !cmd_valid && r.ready;
  assign hi_sum   = {2'b00, r.mh} + {trim[15], trim};
  assign prod_now = 29'($signed(r.sum) * $signed({1'b0, r.scale}));
  assign vin_bad  = cmd.wdata[6:0] < VIN_MANT_MIN ||
                    cmd.wdata[6:0] > VIN_MANT_MAX || cmd.wdata[10:7] != 4'h0;

  mh_reset_a: assert property ($fell(reset) |-> r.mh == MH_RESET[14:0])
    else $error("margin-high not at its reset value");
  ml_reset_a: assert property ($fell(reset) |-> r.ml == ML_RESET[14:0])
    else $error("margin-low not at its reset value");
  mh_store_a: assert property (cmd_take && cmd.write && cmd.code == CODE_MH
    |=> r.mh == $past(cmd.wdata[14:0]) && r.cml == $past(r.cml && !clear_faults))
    else $error("margin-high write altered or checked");
  hi_sum_a: assert property (op_take && op_mode == MODE_HIGH
    |=> r.sum == $past(hi_sum) ##2 vout_cmd == $past(hi_sum, 3))
    else $error("margin-high target not margin plus trim");
  margin_flag_a: assert property (r.st == ST_CHECK &&
    ($signed(r.prod) > $signed({9'h000, REF_HI}) ||
     $signed(r.prod) < $signed({9'h000, REF_LO}))
    |=> r.cml && r.ivd && !smbalert_n)
    else $error("out-of-range margin not flagged");
  margin_clamp_a: assert property (r.st == ST_CHECK &&
    $signed(r.prod) > $signed({9'h000, REF_HI}) |=> ref_cmd == REF_HI)
    else $error("high margin not clamped");
  margin_scale_a: assert property (r.st == ST_MULT &&
    $signed(prod_now) <= $signed({9'h000, REF_HI}) &&
    $signed(prod_now) >= $signed({9'h000, REF_LO})
    |-> ##2 ref_cmd == $past(prod_now[19:0], 2))
    else $error("reference not margin times loop scale");
  scale_read_a: assert property (cmd_take && !cmd.write &&
    cmd.code == CODE_SCALE |=> rsp_valid && rsp_data[15:11] == SCALE_EXP)
    else $error("loop scale exponent not fixed");
  scale_max_a: assert property (r.scale <= SCALE_MANT_MAX && r.scale != 0)
    else $error("loop scale mantissa out of range");
  freq_up_a: assert property (cmd_take && cmd.write && cmd.code == CODE_FREQ
    |=> freq_mant >= $past(cmd.wdata[5:0]) ||
        freq_mant == FREQ_STEP[FREQ_STEPS-1])
    else $error("rate not rounded upward");
  freq_read_a: assert property (cmd_take && !cmd.write &&
    cmd.code == CODE_FREQ |=> rsp_data[15:6] == {FREQ_EXP, 5'h00})
    else $error("rate fixed fields wrong");
  vin_reject_a: assert property (cmd_take && cmd.write &&
    cmd.code == CODE_VIN && vin_bad
    |=> $stable(input_start_threshold_mant) && r.cml && r.ivd)
    else $error("out-of-range turn-on write not refused");
  vin_order_a: assert property (cmd_take && cmd.write &&
    cmd.code == CODE_VIN && !vin_bad && vin_map(cmd.wdata[6:0]) <= vin_off
    |=> $stable(input_start_threshold_mant) && !smbalert_n)
    else $error("turn-on below turn-off accepted");
  store_walk_a: assert property (nvm_valid && !cmd_valid && !op_valid &&
    r.ready && nvm_op == NVM_STORE_ALL |=> mem_we [*5] ##1 cmd_ready)
    else $error("store-all did not write five slots");

endmodule

// >>> tb/pmbmr_host.sv
// host-side model that issues register reads and writes
module pmbmr_host
  import pmbmr_pkg::*;
(
  // clock
  input  wire logic        mclk,
  // command side toward the registers
  output logic             cmd_valid,
  output pmbmr_cmd_t       cmd,
  input  wire logic        cmd_ready,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_ack,
  input  wire logic [15:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hung;
  //////////////////////////////////////////
  // idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
    hung      = 1'b0;
  end
  // request held until taken; released data is inverted so a stale word
  // can never pass for a fresh one
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] wd, output logic ack,
                      output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd       <= '{write: w, code: c, wdata: wd};
    do begin
      @(posedge mclk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    cmd_valid <= 1'b0;
    cmd.wdata <= ~wd;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 100);
    if (n >= 100) hung = 1'b1;
    ack = rsp_ack;
    rd  = rsp_data;
  endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for the margin, scale, rate and turn-on registers
module tb
  import pmbmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          mclk = 1'b0, reset = 1'b1, op_valid = 1'b0;
  logic          nvm_valid = 1'b0, clear_faults = 1'b0;
  logic          cmd_valid, cmd_ready, rsp_valid, rsp_ack, cml, ivd;
  logic          smbalert_n;
  pmbmr_cmd_t    cmd;
  pmbmr_mode_t   op_mode = MODE_NOM;
  pmbmr_nvm_op_t nvm_op = NVM_STORE_ALL;
  logic [15:0]   trim = 16'h0000, rsp_data;
  logic [7:0]    nvm_code = 8'h00;
  logic [6:0]    vin_off = 7'h0a, input_start_threshold_mant;
  logic [19:0]   ref_cmd;
  logic [16:0]   vout_cmd;
  logic [10:0]   scale_mant;
  logic [5:0]    freq_mant, d;
  int            error_cnt = 0, compares = 0;
  logic [5:0]    fs [14] = '{6'h07, 6'h0a, 6'h0d, 6'h10, 6'h13, 6'h16,
    6'h19, 6'h1d, 6'h20, 6'h26, 6'h2c, 6'h32, 6'h39, 6'h3c};
  logic [7:0]    cs [5] = '{CODE_MH, CODE_ML, CODE_SCALE, CODE_FREQ, CODE_VIN};
  logic [15:0]   rv [5] = '{16'h0547, 16'h0451, 16'hb900, 16'h2813,
    16'hf00b};
  //////////////////////////////////////////
  // 250 MHz clock
  always #2 mclk = ~mclk;
  pmbmr_host host_u (.mclk, .cmd_valid, .cmd, .cmd_ready, .rsp_valid,
    .rsp_ack, .rsp_data);
  pmbmr_regs dut_u (.mclk, .reset, .cmd_valid, .cmd, .cmd_ready, .rsp_valid,
    .rsp_ack, .rsp_data, .op_valid, .op_mode, .trim, .vin_off, .nvm_valid,
    .nvm_op, .nvm_code, .clear_faults, .cml, .ivd, .smbalert_n, .ref_cmd,
    .vout_cmd, .scale_mant, .freq_mant, .input_start_threshold_mant);
  // verdict and end of run
  task automatic summarize();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang();
    error_cnt++;
    summarize();
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one command through the host, answer compared as {ack, data}
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] wd,
                     input logic ea, input logic [15:0] ed);
    logic        a;
    logic [15:0] r;
    host_u.xfer(w, c, wd, a, r);
    if (host_u.hung) hang();
    chk({3'h0, a, r}, {3'h0, ea, ed});
  endtask
  // bounded wait for the block to become idle again
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    if (n >= 50) hang();
  endtask
  task automatic op(input pmbmr_mode_t m, input logic [15:0] t,
                    input logic [19:0] e);
    @(posedge mclk);
    op_valid <= 1'b1;
    op_mode  <= m;
    trim     <= t;
    @(posedge mclk);
    op_valid <= 1'b0;
    rdy();
    chk(ref_cmd, e);
  endtask
  task automatic nv(input pmbmr_nvm_op_t o, input logic [7:0] c);
    @(posedge mclk);
    nvm_valid <= 1'b1;
    nvm_op    <= o;
    nvm_code  <= c;
    @(posedge mclk);
    nvm_valid <= 1'b0;
    rdy();
  endtask
  // status is {cml, ivd, smbalert_n}; clearing takes one cycle of request
  task automatic st(input logic [2:0] e);
    chk({17'h0, cml, ivd, smbalert_n}, {17'h0, e});
  endtask
  task automatic clr();
    @(posedge mclk);
    clear_faults <= 1'b1;
    @(posedge mclk);
    clear_faults <= 1'b0;
    @(posedge mclk);
    st(3'b001);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    foreach (cs[i]) acc(1'b0, cs[i], 16'h0, 1'b1, rv[i]);
    acc(1'b0, 8'h27, 16'h0, 1'b0, 16'h0);
    op(MODE_HIGH, 16'h0000, 20'h54700);
    chk({3'h0, vout_cmd}, 20'h00547);
    op(MODE_LOW, 16'h0010, 20'h46100);
    chk({3'h0, vout_cmd}, 20'h00461);
    acc(1'b1, CODE_MH, 16'h0700, 1'b1, 16'h0);
    st(3'b001);
    op(MODE_HIGH, 16'h0000, 20'h60000);
    st(3'b110);
    clr();
    acc(1'b1, CODE_ML, 16'h0300, 1'b1, 16'h0);
    op(MODE_LOW, 16'h0000, 20'h3999a);
    st(3'b110);
    clr();
    op(MODE_NOM, 16'h0000, 20'h4cccd);
    acc(1'b1, CODE_SCALE, 16'hfa00, 1'b1, 16'h0);
    acc(1'b1, CODE_SCALE, 16'h0201, 1'b1, 16'h0);
    chk({9'h0, scale_mant}, 20'h00200);
    st(3'b110);
    clr();
    acc(1'b0, CODE_SCALE, 16'h0, 1'b1, 16'hba00);
    acc(1'b1, CODE_MH, 16'h82a0, 1'b1, 16'h0);
    acc(1'b0, CODE_MH, 16'h0, 1'b1, 16'h02a0);
    op(MODE_HIGH, 16'h0000, 20'h54000);
    op(pmbmr_mode_t'(2'h3), 16'h0000, 20'h4cccd);
    chk({3'h0, vout_cmd}, 20'h00000);
    foreach (fs[i]) begin
      d = (i == 0) ? fs[i] : fs[i] - 6'h01;
      acc(1'b1, CODE_FREQ, {10'h000, d}, 1'b1, 16'h0);
      chk({14'h0, freq_mant}, {14'h0, fs[i]});
    end
    acc(1'b1, CODE_FREQ, 16'hffff, 1'b1, 16'h0);
    acc(1'b0, CODE_FREQ, 16'h0, 1'b1, 16'h283c);
    acc(1'b1, CODE_VIN, 16'h000d, 1'b1, 16'h0);
    acc(1'b0, CODE_VIN, 16'h0, 1'b1, 16'hf00e);
    acc(1'b1, CODE_VIN, 16'h0048, 1'b1, 16'h0);
    acc(1'b1, CODE_VIN, 16'h0049, 1'b1, 16'h0);
    chk({13'h0, input_start_threshold_mant}, 20'h00048);
    st(3'b110);
    clr();
    vin_off <= 7'h14;
    acc(1'b1, CODE_VIN, 16'h0014, 1'b1, 16'h0);
    chk({13'h0, input_start_threshold_mant}, 20'h00048);
    st(3'b110);
    clr();
    nv(NVM_STORE_ONE, CODE_MH);
    acc(1'b1, CODE_MH, 16'h0123, 1'b1, 16'h0);
    nv(NVM_RESTORE_ONE, CODE_MH);
    acc(1'b0, CODE_MH, 16'h0, 1'b1, 16'h02a0);
    nv(NVM_STORE_ALL, 8'h00);
    acc(1'b1, CODE_VIN, 16'h0020, 1'b1, 16'h0);
    nv(NVM_RESTORE_ALL, 8'h00);
    acc(1'b0, CODE_VIN, 16'h0, 1'b1, 16'hf048);
    summarize();
  end
endmodule
